/* design/tcpio_pkg.sv */
// Constants and state types for the channel 4 pin control block
package tcpio_pkg;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 8;
  localparam int IOCTL_W = 8;
  localparam int STAT_W = 2;
  localparam int SYNC_STAGES = 3;

  typedef logic [DATA_W-1:0] tcpio_word_t;
  typedef logic [ADDR_W-1:0] tcpio_addr_t;

  // Register byte offsets
  localparam tcpio_addr_t OFS_STANDBY = 8'h00;
  localparam tcpio_addr_t OFS_IOCTL = 8'h04;
  localparam tcpio_addr_t OFS_GRA = 8'h08;
  localparam tcpio_addr_t OFS_CNT = 8'h0C;
  localparam tcpio_addr_t OFS_RUN = 8'h10;
  localparam tcpio_addr_t OFS_STAT = 8'h14;
  localparam tcpio_addr_t OFS_MASK = 8'h18;

  // Pin control, standby and run field positions
  localparam int BIT_CAPSEL = 3;
  localparam int BIT_INIT = 2;
  localparam int BIT_ACT1 = 1;
  localparam int BIT_ACT0 = 0;
  localparam int BIT_STANDBY = 0;
  localparam int BIT_RUN = 0;

  // Status and mask bit positions
  localparam int ST_MATCH = 0;
  localparam int ST_CAPT = 1;

  // Reset values
  localparam logic RST_STANDBY = 1'b1;
  localparam logic RST_RUN = 1'b0;
  localparam logic [IOCTL_W-1:0] RST_IOCTL = 8'h00;
  localparam tcpio_word_t RST_GRA = 16'hFFFF;
  localparam tcpio_word_t RST_CNT = 16'h0000;
  localparam logic [STAT_W-1:0] RST_STAT = 2'h0;
  localparam logic [STAT_W-1:0] RST_MASK = 2'h0;
  localparam logic RST_PIN = 1'b0;
  localparam logic RST_OE = 1'b1;
  localparam tcpio_word_t WORD_ZERO = 16'h0000;

  // Compare actions, from the low two bits of the pin control field
  localparam logic [1:0] ACT_HOLD = 2'h0;
  localparam logic [1:0] ACT_LOW = 2'h1;
  localparam logic [1:0] ACT_HIGH = 2'h2;
  localparam logic [1:0] ACT_TOGGLE = 2'h3;

  typedef enum logic [1:0] {
    EDGE_RISE,
    EDGE_FALL,
    EDGE_BOTH
  } tcpio_edge_e;

  typedef struct packed {
    logic [SYNC_STAGES-1:0] stg;
    logic level;
  } tcpio_sync_s;

  typedef struct packed {
    tcpio_word_t count;
  } tcpio_cnt_s;

  typedef struct packed {
    logic standby;
    logic run;
    logic [IOCTL_W-1:0] ioctl;
    tcpio_word_t gra;
    logic [STAT_W-1:0] stat;
    logic [STAT_W-1:0] mask;
    logic pin;
    logic oe;
    logic irq;
    tcpio_word_t rdata;
  } tcpio_top_s;
endpackage : tcpio_pkg

/* design/tcpio_sync.sv */
// Three-stage pin synchroniser with agreement filter and edge pulses
`timescale 1ns/1ns
module tcpio_sync (
  // Clock and control
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  // Raw pin
  input wire logic pin_raw,
  // Filtered level and edges
  output logic level,
  output logic rise,
  output logic fall
);
  import tcpio_pkg::*;

  tcpio_sync_s s_q;
  tcpio_sync_s s_d;
  logic agree;

  // Stage 0 is read only by stage 1
  assign agree = (s_q.stg[1] == s_q.stg[2]);

  always_comb begin
    s_d = s_q;
    s_d.stg = {s_q.stg[1:0], pin_raw};
    if (agree) begin
      s_d.level = s_q.stg[2];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign level = s_q.level;
  assign rise = agree && s_q.stg[2] && !s_q.level;
  assign fall = agree && !s_q.stg[2] && s_q.level;
endmodule : tcpio_sync

/* design/tcpio_counter.sv */
// Channel 4 up counter with software load
`timescale 1ns/1ns
module tcpio_counter (
  // Clock and control
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic en,
  // Load port
  input wire logic ld,
  input wire tcpio_pkg::tcpio_word_t ld_val,
  // Count
  output tcpio_pkg::tcpio_word_t count
);
  import tcpio_pkg::*;

  tcpio_cnt_s s_q;
  tcpio_cnt_s s_d;

  // Load wins over counting
  always_comb begin
    s_d = s_q;
    if (ld) begin
      s_d.count = ld_val;
    end else if (en) begin
      s_d.count = s_q.count + 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_q.count <= RST_CNT;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign count = s_q.count;
endmodule : tcpio_counter

/* design/tcpio_top.sv */
// Channel 4 general register A: compare output and input capture on pin A
//
// Chosen here: the address map and the address-and-strobe port.
`timescale 1ns/1ns
module tcpio_top (
  // Clock, reset, enable
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire logic CE,
  // Register port
  input wire tcpio_pkg::tcpio_addr_t ADDR,
  input wire tcpio_pkg::tcpio_word_t WR_DATA,
  input wire logic WR_STB,
  input wire logic RD_STB,
  output tcpio_pkg::tcpio_word_t RD_DATA,
  // Timer pin A
  input wire logic PIN_IN,
  output logic PIN_OUT,
  output logic PIN_OE,
  // Interrupt
  output logic IRQ
);
  import tcpio_pkg::*;

  tcpio_top_s s_q;
  tcpio_top_s s_d;
  tcpio_word_t cnt;
  logic pin_rise;
  logic pin_fall;
  logic acc_ok;
  logic running;
  logic capmode;
  logic io_wr;
  logic gra_wr;
  logic cnt_ld;
  logic cmp_hit;
  logic cap_evt;
  logic [1:0] act;
  tcpio_edge_e edge_sel;
  logic [STAT_W-1:0] st_set;
  logic [STAT_W-1:0] st_clr;

  tcpio_sync u_sync (
    .clk(REF_CLK),
    .reset(RESET),
    .ce(CE),
    .pin_raw(PIN_IN),
    .level(),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  tcpio_counter u_cnt (
    .clk(REF_CLK),
    .reset(RESET),
    .ce(CE),
    .en(running),
    .ld(cnt_ld),
    .ld_val(WR_DATA),
    .count(cnt)
  );

  assign acc_ok = !s_q.standby;
  assign running = acc_ok && s_q.run;
  assign capmode = s_q.ioctl[BIT_CAPSEL];
  assign act = s_q.ioctl[BIT_ACT1:BIT_ACT0];
  assign io_wr = WR_STB && acc_ok && (ADDR == OFS_IOCTL);
  assign gra_wr = WR_STB && acc_ok && (ADDR == OFS_GRA);
  assign cnt_ld = WR_STB && acc_ok && (ADDR == OFS_CNT);

  assign cmp_hit = running && !capmode && (cnt == s_q.gra);

  // Edge select, bits 2 and 0 ignored when bit 1 set
  always_comb begin
    edge_sel = EDGE_RISE;
    if (s_q.ioctl[BIT_ACT1]) begin
      edge_sel = EDGE_BOTH;
    end else if (s_q.ioctl[BIT_ACT0]) begin
      edge_sel = EDGE_FALL;
    end
  end

  always_comb begin
    cap_evt = 1'b0;
    if (acc_ok && capmode) begin
      case (edge_sel)
        EDGE_RISE: cap_evt = pin_rise;
        EDGE_FALL: cap_evt = pin_fall;
        default: cap_evt = pin_rise || pin_fall;
      endcase
    end
  end

  always_comb begin
    st_set = '0;
    st_set[ST_MATCH] = cmp_hit;
    st_set[ST_CAPT] = cap_evt;
    st_clr = '0;
    if (RD_STB && acc_ok && (ADDR == OFS_STAT)) begin
      st_clr = '1;
    end
  end

  always_comb begin
    s_d = s_q;
    s_d.rdata = WORD_ZERO;
    // Standby bit stays reachable so software can leave standby
    if (WR_STB) begin
      if (ADDR == OFS_STANDBY) begin
        s_d.standby = WR_DATA[BIT_STANDBY];
      end else if (!acc_ok) begin
        s_d.standby = s_q.standby;
      end else if (ADDR == OFS_IOCTL) begin
        s_d.ioctl = WR_DATA[IOCTL_W-1:0];
      end else if (ADDR == OFS_GRA) begin
        s_d.gra = WR_DATA;
      end else if (ADDR == OFS_RUN) begin
        s_d.run = WR_DATA[BIT_RUN];
      end else if (ADDR == OFS_MASK) begin
        s_d.mask = WR_DATA[STAT_W-1:0];
      end
    end
    if (RD_STB) begin
      if (ADDR == OFS_STANDBY) begin
        s_d.rdata[BIT_STANDBY] = s_q.standby;
      end else if (!acc_ok) begin
        s_d.rdata = WORD_ZERO;
      end else if (ADDR == OFS_IOCTL) begin
        s_d.rdata[IOCTL_W-1:0] = s_q.ioctl;
      end else if (ADDR == OFS_GRA) begin
        s_d.rdata = s_q.gra;
      end else if (ADDR == OFS_CNT) begin
        s_d.rdata = cnt;
      end else if (ADDR == OFS_RUN) begin
        s_d.rdata[BIT_RUN] = s_q.run;
      end else if (ADDR == OFS_STAT) begin
        s_d.rdata[STAT_W-1:0] = s_q.stat;
      end else if (ADDR == OFS_MASK) begin
        s_d.rdata[STAT_W-1:0] = s_q.mask;
      end
    end
    // Capture beats a software write to the same register
    if (cap_evt) begin
      s_d.gra = cnt;
    end
    // Set wins over read-clear
    s_d.stat = (s_q.stat & ~st_clr) | st_set;
    s_d.irq = |(s_d.stat & s_d.mask);
    s_d.oe = !s_d.ioctl[BIT_CAPSEL];
    // initial level on write; codes 0 and 4 keep the level
    if (io_wr) begin
      if (!WR_DATA[BIT_CAPSEL] && (WR_DATA[BIT_ACT1:BIT_ACT0] != ACT_HOLD)) begin
        s_d.pin = WR_DATA[BIT_INIT];
      end
    end else if (cmp_hit) begin
      case (act)
        ACT_LOW: s_d.pin = 1'b0;
        ACT_HIGH: s_d.pin = 1'b1;
        ACT_TOGGLE: s_d.pin = !s_q.pin;
        default: s_d.pin = s_q.pin;
      endcase
    end
  end

  // reset values, standby set and pin low
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      s_q.standby <= RST_STANDBY;
      s_q.run <= RST_RUN;
      s_q.ioctl <= RST_IOCTL;
      s_q.gra <= RST_GRA;
      s_q.stat <= RST_STAT;
      s_q.mask <= RST_MASK;
      s_q.pin <= RST_PIN;
      s_q.oe <= RST_OE;
      s_q.irq <= 1'b0;
      s_q.rdata <= WORD_ZERO;
    end else if (CE) begin
      s_q <= s_d;
    end
  end

  assign RD_DATA = s_q.rdata;
  assign PIN_OUT = s_q.pin;
  assign PIN_OE = s_q.oe;
  assign IRQ = s_q.irq;

  // Checks
  logic io_wr_lo;
  logic io_wr_hi;
  assign io_wr_lo = io_wr && !WR_DATA[BIT_CAPSEL] && !WR_DATA[BIT_INIT]
                    && (WR_DATA[BIT_ACT1:BIT_ACT0] != ACT_HOLD);
  assign io_wr_hi = io_wr && !WR_DATA[BIT_CAPSEL] && WR_DATA[BIT_INIT]
                    && (WR_DATA[BIT_ACT1:BIT_ACT0] != ACT_HOLD);

  a_init_low: assert property (@(posedge REF_CLK) disable iff (RESET)
    CE && io_wr_lo |=> !PIN_OUT && PIN_OE)
    else $error("pin not low after low-start code");

  a_init_high: assert property (@(posedge REF_CLK) disable iff (RESET)
    CE && io_wr_hi |=> PIN_OUT && PIN_OE)
    else $error("pin not high after high-start code");

  a_match_drive: assert property (@(posedge REF_CLK) disable iff (RESET)
    CE && cmp_hit && !io_wr && (act == ACT_HIGH || act == ACT_LOW)
    |=> PIN_OUT == ($past(act) == ACT_HIGH))
    else $error("pin level wrong after compare match");

  a_toggle_match: assert property (@(posedge REF_CLK) disable iff (RESET)
    CE && cmp_hit && !io_wr && (act == ACT_TOGGLE) |=> PIN_OUT != $past(PIN_OUT))
    else $error("toggle did not invert pin");

  a_hold_match: assert property (@(posedge REF_CLK) disable iff (RESET)
    CE && cmp_hit && !io_wr && (act == ACT_HOLD) |=> $stable(PIN_OUT))
    else $error("pin moved on hold code");

  a_reset_pin: assert property (@(posedge REF_CLK)
    RESET |=> !PIN_OUT && PIN_OE && !IRQ)
    else $error("pin not low after reset");

  a_cap_rise: assert property (@(posedge REF_CLK) disable iff (RESET)
    CE && acc_ok && capmode && !s_q.ioctl[BIT_ACT1] && !s_q.ioctl[BIT_ACT0] && pin_rise
    |=> s_q.gra == $past(cnt) && s_q.stat[ST_CAPT])
    else $error("rising edge capture missed");

  a_cap_fall: assert property (@(posedge REF_CLK) disable iff (RESET)
    CE && acc_ok && capmode && !s_q.ioctl[BIT_ACT1] && s_q.ioctl[BIT_ACT0] && pin_fall
    |=> s_q.gra == $past(cnt))
    else $error("falling edge capture missed");

  a_cap_both: assert property (@(posedge REF_CLK) disable iff (RESET)
    CE && acc_ok && capmode && s_q.ioctl[BIT_ACT1] && (pin_rise || pin_fall)
    |=> s_q.gra == $past(cnt))
    else $error("both edge capture missed");

  a_no_cap_rise: assert property (@(posedge REF_CLK) disable iff (RESET)
    CE && capmode && !s_q.ioctl[BIT_ACT1] && s_q.ioctl[BIT_ACT0] && !pin_fall && !gra_wr
    |=> $stable(s_q.gra))
    else $error("capture on wrong edge");

  a_standby_reset: assert property (@(posedge REF_CLK)
    RESET ##1 !RESET |-> s_q.standby && !running)
    else $error("module not in standby after reset");

  a_standby_halt: assert property (@(posedge REF_CLK) disable iff (RESET)
    s_q.standby && !cnt_ld |=> $stable(cnt))
    else $error("counter moved in standby");

  a_standby_read: assert property (@(posedge REF_CLK) disable iff (RESET)
    CE && RD_STB && s_q.standby && (ADDR != OFS_STANDBY) |=> RD_DATA == WORD_ZERO)
    else $error("read answered in standby");

  a_standby_write: assert property (@(posedge REF_CLK) disable iff (RESET)
    s_q.standby && !cap_evt |=> $stable(s_q.gra) && $stable(s_q.ioctl))
    else $error("write taken in standby");

  a_match_flag: assert property (@(posedge REF_CLK) disable iff (RESET)
    CE && running && !capmode && (cnt == s_q.gra) |=> s_q.stat[ST_MATCH])
    else $error("match flag not set");

  a_irq_level: assert property (@(posedge REF_CLK) disable iff (RESET)
    IRQ == |(s_q.stat & s_q.mask))
    else $error("interrupt disagrees with status");

  a_init_hold: assert property (@(posedge REF_CLK) disable iff (RESET)
    CE && io_wr && !WR_DATA[BIT_CAPSEL] && (WR_DATA[BIT_ACT1:BIT_ACT0] == ACT_HOLD)
    |=> $stable(PIN_OUT))
    else $error("pin moved on hold code write");

  a_oe_compare: assert property (@(posedge REF_CLK) disable iff (RESET)
    CE && io_wr && !WR_DATA[BIT_CAPSEL] |=> PIN_OE)
    else $error("pin not driven in compare mode");

  a_oe_capture: assert property (@(posedge REF_CLK) disable iff (RESET)
    CE && io_wr && WR_DATA[BIT_CAPSEL] |=> !PIN_OE)
    else $error("pin still driven in capture mode");

  a_cap_pin_hold: assert property (@(posedge REF_CLK) disable iff (RESET)
    CE && capmode && !io_wr |=> $stable(PIN_OUT))
    else $error("pin moved in capture mode");

  a_no_cap_fall: assert property (@(posedge REF_CLK) disable iff (RESET)
    CE && capmode && !s_q.ioctl[BIT_ACT1] && !s_q.ioctl[BIT_ACT0] && !pin_rise && !gra_wr
    |=> $stable(s_q.gra))
    else $error("rising edge mode captured on wrong edge");

  a_count_step: assert property (@(posedge REF_CLK) disable iff (RESET)
    CE && running && !cnt_ld |=> cnt == $past(cnt) + 16'h0001)
    else $error("counter did not step while running");

  a_count_load: assert property (@(posedge REF_CLK) disable iff (RESET)
    CE && cnt_ld |=> cnt == $past(WR_DATA))
    else $error("counter load lost");

  a_count_halt: assert property (@(posedge REF_CLK) disable iff (RESET)
    CE && !running && !cnt_ld |=> $stable(cnt))
    else $error("counter moved while halted");

  a_standby_idle: assert property (@(posedge REF_CLK) disable iff (RESET)
    s_q.standby |-> !cmp_hit && !cap_evt && !io_wr && !gra_wr && !cnt_ld)
    else $error("event or access taken in standby");

  a_stat_read: assert property (@(posedge REF_CLK) disable iff (RESET)
    CE && RD_STB && acc_ok && (ADDR == OFS_STAT) |=> RD_DATA[STAT_W-1:0] == $past(s_q.stat))
    else $error("status read returned wrong bits");

  a_stat_clear: assert property (@(posedge REF_CLK) disable iff (RESET)
    CE && st_clr[ST_MATCH] && !cmp_hit && !cap_evt |=> s_q.stat == RST_STAT)
    else $error("status not cleared by read");

  a_rd_idle: assert property (@(posedge REF_CLK) disable iff (RESET)
    CE && !RD_STB |=> RD_DATA == WORD_ZERO)
    else $error("read data outside read cycle");

  c_toggle: cover property (@(posedge REF_CLK) disable iff (RESET)
    CE && cmp_hit && (act == ACT_TOGGLE));
  c_cap_rise: cover property (@(posedge REF_CLK) disable iff (RESET)
    CE && cap_evt && (edge_sel == EDGE_RISE));
  c_cap_both: cover property (@(posedge REF_CLK) disable iff (RESET)
    CE && cap_evt && (edge_sel == EDGE_BOTH));
  c_cap_fall: cover property (@(posedge REF_CLK) disable iff (RESET)
    CE && cap_evt && (edge_sel == EDGE_FALL));
  c_irq: cover property (@(posedge REF_CLK) disable iff (RESET) $rose(IRQ));
endmodule : tcpio_top

/* dv/tcpio_pin_src.sv */
// Outside source model for timer pin A
`timescale 1ns/1ns
module tcpio_pin_src (
  // Clock
  input wire logic clk,
  // Design side of the pin
  input wire logic pin_out,
  input wire logic pin_oe,
  // Resolved pin level
  output logic pin_lvl
);
  logic src_q = 1'b0;

  // wide pulses
  // Level held 4 clocks, well above the minimum width
  task automatic drive(input logic v);
    @(posedge clk);
    src_q <= v;
    repeat (4) @(posedge clk);
  endtask : drive

  // Design wins the wire while it drives
  assign pin_lvl = pin_oe ? pin_out : src_q;
endmodule : tcpio_pin_src

/* dv/tb_tcpio_top.sv */
// Self-checking bench for the channel 4 pin control block
`timescale 1ns/1ns
module tb_tcpio_top;
  import tcpio_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  tcpio_addr_t addr = 8'h00;
  tcpio_word_t wdata = 16'h0000;
  logic wstb = 1'b0;
  logic rstb = 1'b0;
  tcpio_word_t rdata;
  logic pin_in;
  logic pin_out;
  logic pin_oe;
  logic irq;
  int error_cnt = 0;
  int samples_checked = 0;
  int seed = 32'h03128247;
  logic exp_pin;
  tcpio_word_t k;
  logic [3:0] code;
  // Reference model fed only by bench stimulus and the pin wire
  int m_cnt = 0;
  int m_gra = 0;
  logic m_sby = 1'b1;
  logic m_run = 1'b0;
  logic [3:0] m_code = 4'h0;
  logic [2:0] m_stg = 3'h0;
  logic m_lvl = 1'b0;
  logic m_edge;

  assign m_edge = (m_stg[1] == m_stg[2]) && (m_stg[2] != m_lvl);

  always @(posedge clk) begin
    if (rst) begin
      m_cnt <= 0;
      m_gra <= RST_GRA;
      m_sby <= 1'b1;
      m_run <= 1'b0;
      m_code <= 4'h0;
      m_stg <= 3'h0;
      m_lvl <= 1'b0;
    end else if (ce) begin
      m_stg <= {m_stg[1:0], pin_in};
      if (m_stg[1] == m_stg[2]) begin
        m_lvl <= m_stg[2];
      end
      if (m_run && !m_sby) begin
        m_cnt <= (m_cnt + 1) % 65536;
      end
      if (wstb && addr == OFS_STANDBY) begin
        m_sby <= wdata[0];
      end else if (wstb && !m_sby) begin
        if (addr == OFS_IOCTL) begin
          m_code <= wdata[3:0];
        end
        if (addr == OFS_GRA) begin
          m_gra <= wdata;
        end
        if (addr == OFS_CNT) begin
          m_cnt <= wdata;
        end
        if (addr == OFS_RUN) begin
          m_run <= wdata[0];
        end
      end
      if (!m_sby && m_code[3] && m_edge && (m_code[1] || (m_code[0] != m_stg[2]))) begin
        m_gra <= m_cnt;
      end
    end
  end

  tcpio_top u_tcpio_top (.REF_CLK(clk), .RESET(rst), .CE(ce), .ADDR(addr), .WR_DATA(wdata),
    .WR_STB(wstb), .RD_STB(rstb), .RD_DATA(rdata), .PIN_IN(pin_in), .PIN_OUT(pin_out),
    .PIN_OE(pin_oe), .IRQ(irq));
  tcpio_pin_src u_tcpio_pin_src (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_lvl(pin_in));

  initial begin
    forever #10 clk = ~clk;
  end

  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : final_report

  task automatic chk(input tcpio_word_t got, input tcpio_word_t exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input tcpio_addr_t a, input tcpio_word_t d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wstb <= 1'b1;
    @(posedge clk);
    wstb <= 1'b0;
  endtask : wr

  // Data stands only in the cycle after the strobe
  task automatic rdchk(input tcpio_addr_t a, input tcpio_word_t e);
    @(posedge clk);
    addr <= a;
    rstb <= 1'b1;
    @(posedge clk);
    rstb <= 1'b0;
    @(negedge clk);
    chk(rdata, e);
  endtask : rdchk

  task automatic pchk(input logic oe);
    repeat (2) @(negedge clk);
    chk({15'h0000, pin_out}, {15'h0000, exp_pin});
    chk({15'h0000, pin_oe}, {15'h0000, oe});
  endtask : pchk

  // Interrupt level first, then a clearing read
  task automatic stat_chk(input tcpio_word_t e);
    @(negedge clk);
    chk({15'h0000, irq}, {15'h0000, e != 16'h0000});
    rdchk(OFS_STAT, e);
  endtask : stat_chk

  // One counter pass over the compare value
  task automatic cmp_pass;
    wr(OFS_CNT, k);
    wr(OFS_RUN, 16'h0001);
    repeat (8) @(posedge clk);
    wr(OFS_RUN, 16'h0000);
    case (code[1:0])
      2'h1: exp_pin = 1'b0;
      2'h2: exp_pin = 1'b1;
      2'h3: exp_pin = ~exp_pin;
      default: exp_pin = exp_pin;
    endcase
  endtask : cmp_pass

  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    final_report();
  end

  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    exp_pin = RST_PIN;
    pchk(1'b1);
    rdchk(OFS_STANDBY, 16'h0001);
    wr(OFS_GRA, 16'h1234);
    rdchk(OFS_GRA, 16'h0000);
    wr(OFS_STANDBY, 16'h0000);
    rdchk(OFS_GRA, RST_GRA);
    wr(8'h1C, 16'h5A5A);
    rdchk(8'h1C, 16'h0000);
    rdchk(OFS_IOCTL, 16'h0000);
    wr(OFS_MASK, 16'h0003);
    $display("test access done");
    wr(OFS_CNT, 16'h0100);
    wr(OFS_RUN, 16'h0001);
    @(posedge clk);
    ce <= 1'b0;
    repeat (5) @(posedge clk);
    ce <= 1'b1;
    wr(OFS_RUN, 16'h0000);
    @(negedge clk);
    rdchk(OFS_CNT, tcpio_word_t'(m_cnt));
    $display("test enable done");
    for (int c = 0; c < 8; c++) begin
      code = c[3:0];
      k = tcpio_word_t'($random(seed)) & 16'h0FF0;
      wr(OFS_GRA, k + 16'h0004);
      wr(OFS_IOCTL, {12'h000, code});
      rdchk(OFS_IOCTL, {12'h000, code});
      if (code[1:0] != 2'h0) begin
        exp_pin = code[2];
      end
      pchk(1'b1);
      cmp_pass();
      pchk(1'b1);
      cmp_pass();
      pchk(1'b1);
      stat_chk(16'h0001);
    end
    $display("test compare done");
    for (int c = 8; c < 16; c++) begin
      code = c[3:0];
      wr(OFS_IOCTL, 16'h0001);
      exp_pin = 1'b0;
      pchk(1'b1);
      wr(OFS_IOCTL, {12'h000, code});
      wr(OFS_RUN, 16'h0001);
      pchk(1'b0);
      stat_chk(16'h0000);
      u_tcpio_pin_src.drive(1'b1);
      repeat (2) @(posedge clk);
      stat_chk((code[1] | ~code[0]) ? 16'h0002 : 16'h0000);
      rdchk(OFS_GRA, tcpio_word_t'(m_gra));
      u_tcpio_pin_src.drive(1'b0);
      repeat (2) @(posedge clk);
      stat_chk((code[1] | code[0]) ? 16'h0002 : 16'h0000);
      rdchk(OFS_GRA, tcpio_word_t'(m_gra));
      wr(OFS_RUN, 16'h0000);
      wr(OFS_GRA, RST_GRA);
      wr(OFS_CNT, 16'h0000);
    end
    $display("test capture done");
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    exp_pin = RST_PIN;
    pchk(1'b1);
    rdchk(OFS_STANDBY, 16'h0001);
    wr(OFS_IOCTL, 16'h0003);
    rdchk(OFS_IOCTL, 16'h0000);
    $display("test reset done");
    final_report();
  end
endmodule : tb_tcpio_top
